// ==== pkg/csp_pkg.sv ====
// csp_pkg: shared constants and types for the chip-select and coprocessor pin block
// assumes: one clock domain, no register bus
package csp_pkg;
   // ==========================================================
   // widths and counts
   localparam int ADDR_W     = 20;
   localparam int PERIPH_N   = 7;
   localparam int MID_N      = 4;
   localparam int PERIPH_LOW = 5;
   // ==========================================================
   // reset values and codes
   localparam logic [3:0] MID_IDLE       = 4'hf;
   localparam logic [6:0] PERIPH_IDLE    = 7'h7f;
   localparam logic [7:0] ERR_INT_TYPE   = 8'h10;
   localparam int         ADDR1_POS      = 1;
   localparam int         ADDR2_POS      = 2;
   localparam int         COPROC_REQ_POS = 0;
   localparam int         COPROC_ERR_POS = 1;
   localparam int         COPROC_SEL_POS = 3;
   localparam int         SYNC_STAGES    = 2;
   // ==========================================================
   // coprocessor handshake states
   typedef enum logic [2:0] {
      CSP_IDLE  = 3'b001,
      CSP_CHECK = 3'b010,
      CSP_RUN   = 3'b100
   } csp_state_e;
endpackage

// ==== pkg/csp_range_if.sv ====
// csp_range_if: address and limits carried to the range comparator
// assumes: driver and comparator share one clock
`timescale 1ns/1ps
interface csp_range_if;
   logic [csp_pkg::ADDR_W-1:0] addr;
   logic [csp_pkg::ADDR_W-1:0] lo;
   logic [csp_pkg::ADDR_W-1:0] hi;
   logic                       hit;
   modport src (output addr, output lo, output hi, input hit);
   modport cmp (input addr, input lo, input hi, output hit);
endinterface

// ==== rtl/csp_chip_select.sv ====
// csp_chip_select: mid-range and peripheral select pins plus coprocessor handshake
// assumes: bus cycle strobe from the core on clk_i; coprocessor pins are asynchronous
`timescale 1ns/1ps
// How it works
// - enabled mid-range selects go low for memory cycles inside mid limits only
// - numerics mode on 16-bit variant turns three mid pins into coprocessor handshake
// - error sampled at each numerics operation start; active raises interrupt type 16
// - coprocessor select goes active whenever the core accesses the coprocessor while numerics mode is on
// - each of five peripheral selects goes low when memory or io address hits
// - upper two peripheral pins are extra selects or latched address bits two and one
// - mid pins decode addresses only while their function is enabled
module csp_chip_select
#(
   parameter bit WIDE_BUS = 1'b1
)
(
   input  wire logic                                          clk_i,
   input  wire logic                                          rst_n_i,
   input  wire logic                                          cycle_valid_i,
   input  wire logic                                          cycle_is_io_i,
   input  wire logic [csp_pkg::ADDR_W-1:0]                    cycle_addr_i,
   input  wire logic                                          mid_enable_i,
   input  wire logic [csp_pkg::ADDR_W-1:0]                    mid_lo_i,
   input  wire logic [csp_pkg::ADDR_W-1:0]                    mid_hi_i,
   input  wire logic [csp_pkg::PERIPH_N*csp_pkg::ADDR_W-1:0]  periph_lo_i,
   input  wire logic [csp_pkg::PERIPH_N*csp_pkg::ADDR_W-1:0]  periph_hi_i,
   input  wire logic                                          addr_out_mode_i,
   input  wire logic                                          numerics_mode_i,
   input  wire logic                                          coproc_access_i,
   input  wire logic                                          numerics_op_start_i,
   input  wire logic                                          coproc_transfer_request_i,
   input  wire logic                                          coproc_error_i,
   output logic [csp_pkg::MID_N-1:0]                          mid_range_select_n_o,
   output logic [csp_pkg::PERIPH_LOW-1:0]                     peripheral_select_n_o,
   output logic                                               periph_select5_or_addr1_o,
   output logic                                               periph_select6_or_addr2_o,
   output logic                                               coproc_request_seen_o,
   output logic                                               coproc_busy_o,
   output logic                                               err_irq_o,
   output logic [7:0]                                         err_irq_type_o
);
   import csp_pkg::*;

   // ==========================================================
   // pin positions
   localparam int SEL5_PIN = PERIPH_LOW;
   localparam int SEL6_PIN = PERIPH_LOW + 1;

   // address bit shown on an upper peripheral pin
   function automatic logic addr_pin_bit(input logic [ADDR_W-1:0] a, input int pin);
      return (pin == SEL5_PIN) ? a[ADDR1_POS] : a[ADDR2_POS];
   endfunction

   // ==========================================================
   // input synchronisers
   logic [SYNC_STAGES-1:0] req_sync;
   logic [SYNC_STAGES-1:0] err_sync;
   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         req_sync <= '0;
         err_sync <= '0;
      end
      else
      begin
         req_sync <= {req_sync[0], coproc_transfer_request_i};
         err_sync <= {err_sync[0], coproc_error_i};
      end
   end
   wire req_s = req_sync[SYNC_STAGES-1];
   wire err_s = err_sync[SYNC_STAGES-1];

   // ==========================================================
   // range compare
   wire               numerics_on = numerics_mode_i && WIDE_BUS;
   wire               mid_decode  = mid_enable_i && cycle_valid_i && !cycle_is_io_i;
   wire [PERIPH_N-1:0] periph_hit;
   wire               mid_hit;

   csp_range_if mid_rng();
   assign mid_rng.addr = cycle_addr_i;
   assign mid_rng.lo   = mid_lo_i;
   assign mid_rng.hi   = mid_hi_i;
   assign mid_hit      = mid_rng.hit;
   csp_range_cmp u_mid (.rng(mid_rng));

   genvar g;
   generate
      for (g = 0; g < PERIPH_N; g++)
      begin : g_periph
         csp_range_if p_rng();
         assign p_rng.addr    = cycle_addr_i;
         assign p_rng.lo      = periph_lo_i[g*ADDR_W +: ADDR_W];
         assign p_rng.hi      = periph_hi_i[g*ADDR_W +: ADDR_W];
         assign periph_hit[g] = p_rng.hit && cycle_valid_i;
         csp_range_cmp u_cmp (.rng(p_rng));
      end
   endgenerate

   // ==========================================================
   // next pin values
   logic [MID_N-1:0]    mid_n;
   logic [PERIPH_N-1:0] periph_n;
   wire                 mid_low      = mid_decode && mid_hit;
   wire                 coproc_sel_n = !(coproc_access_i && cycle_valid_i);
   wire [MID_N-1:0]     mid_plain_n  = mid_low ? '0 : MID_IDLE;
   wire [MID_N-1:0]     next_mid_n;
   wire [PERIPH_N-1:0]  next_periph_n;

   genvar m;
   generate
      for (m = 0; m < MID_N; m++)
      begin : g_mid
         if (m == COPROC_SEL_POS)
         begin : g_sel
            assign next_mid_n[m] = numerics_on ? coproc_sel_n : mid_plain_n[m];
         end
         else if (m == COPROC_REQ_POS || m == COPROC_ERR_POS)
         begin : g_in
            assign next_mid_n[m] = numerics_on || mid_plain_n[m];
         end
         else
         begin : g_plain
            assign next_mid_n[m] = mid_plain_n[m];
         end
      end
   endgenerate

   genvar p;
   generate
      for (p = 0; p < PERIPH_N; p++)
      begin : g_pin
         if (p >= SEL5_PIN)
         begin : g_upper
            assign next_periph_n[p] = !addr_out_mode_i ? !periph_hit[p]
                                    : cycle_valid_i    ? addr_pin_bit(cycle_addr_i, p) : periph_n[p];
         end
         else
         begin : g_lower
            assign next_periph_n[p] = !periph_hit[p];
         end
      end
   endgenerate

   // ==========================================================
   // registered pins
   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         mid_n    <= MID_IDLE;
         periph_n <= PERIPH_IDLE;
      end
      else
      begin
         mid_n    <= next_mid_n;
         periph_n <= next_periph_n;
      end
   end
   assign mid_range_select_n_o      = mid_n;
   assign peripheral_select_n_o     = periph_n[PERIPH_LOW-1:0];
   assign periph_select5_or_addr1_o = periph_n[SEL5_PIN];
   assign periph_select6_or_addr2_o = periph_n[SEL6_PIN];

   // ==========================================================
   // coprocessor handshake
   csp_state_e state;
   csp_state_e next_state;
   always_comb
   begin
      next_state = state;
      case (state)
         CSP_IDLE:
            if (numerics_on && numerics_op_start_i)
               next_state = CSP_CHECK;
         CSP_CHECK:
            next_state = CSP_RUN;
         CSP_RUN:
            if (!numerics_on || !req_s)
               next_state = CSP_IDLE;
         default:
            next_state = CSP_IDLE;
      endcase
   end
   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
         state <= CSP_IDLE;
      else
         state <= next_state;
   end

   // ==========================================================
   // error interrupt and request flag
   logic       irq;
   logic [7:0] irq_type;
   logic       seen;
   wire        sample_err = numerics_on && numerics_op_start_i;
   wire        raise_irq  = sample_err && err_s;
   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         irq      <= 1'b0;
         irq_type <= 8'h00;
         seen     <= 1'b0;
      end
      else
      begin
         irq      <= raise_irq;
         irq_type <= raise_irq ? ERR_INT_TYPE : 8'h00;
         seen     <= numerics_on && req_s;
      end
   end

   // ==========================================================
   // outputs
   assign err_irq_o             = irq;
   assign err_irq_type_o        = irq_type;
   assign coproc_request_seen_o = seen;
   assign coproc_busy_o         = (state != CSP_IDLE);
endmodule // csp_chip_select

// ==== rtl/csp_range_cmp.sv ====
// csp_range_cmp: inclusive lower/upper limit comparator
// assumes: limits are stable during a bus cycle
`timescale 1ns/1ps
module csp_range_cmp
(
   csp_range_if.cmp rng
);
   import csp_pkg::*;
   // ==========================================================
   // compare
   assign rng.hit = (rng.addr >= rng.lo) && (rng.addr <= rng.hi);
endmodule // csp_range_cmp

// ==== verification/csp_chip_select_asserts.sv ====
// csp_chk: concurrent checks on the chip-select and coprocessor pins
// assumes: bound to csp_chip_select, WIDE_BUS left at 1
`timescale 1ns/1ps
module csp_chk import csp_pkg::*;
(
   input wire logic                       clk_i, rst_n_i, cycle_valid_i, cycle_is_io_i, mid_enable_i,
   input wire logic                       addr_out_mode_i, numerics_mode_i, coproc_access_i,
   input wire logic                       numerics_op_start_i, coproc_error_i, err_irq_o, periph_select5_or_addr1_o,
   input wire logic [ADDR_W-1:0]          cycle_addr_i, mid_lo_i, mid_hi_i,
   input wire logic [PERIPH_N*ADDR_W-1:0] periph_lo_i, periph_hi_i,
   input wire logic [MID_N-1:0]           mid_range_select_n_o,
   input wire logic [PERIPH_LOW-1:0]      peripheral_select_n_o,
   input wire logic [7:0]                 err_irq_type_o
);
   // ==========================================================
   // expected decode
   logic live;
   wire  mhit = cycle_valid_i && !cycle_is_io_i && mid_enable_i && cycle_addr_i >= mid_lo_i && cycle_addr_i <= mid_hi_i;
   wire  phit = cycle_valid_i && cycle_addr_i >= periph_lo_i[ADDR_W-1:0] && cycle_addr_i <= periph_hi_i[ADDR_W-1:0];
   always_ff @(posedge clk_i) live <= rst_n_i;
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   sequence s_err_op; coproc_error_i [*4] ##0 numerics_op_start_i; endsequence
   // ==========================================================
   // properties
   property p_mid_hit; live && $past(mhit) |-> !mid_range_select_n_o[2]; endproperty
   a_mid_hit: assert property (p_mid_hit) else $error("mid select missed a hit");
   property p_mid_off; live && !$past(mhit) |-> mid_range_select_n_o[2]; endproperty
   a_mid_off: assert property (p_mid_off) else $error("mid select low without hit");
   property p_num; live && $past(numerics_mode_i) |-> &mid_range_select_n_o[1:0]; endproperty
   a_num: assert property (p_num) else $error("handshake pins driven low");
   property p_csel; live && $past(numerics_mode_i && coproc_access_i && cycle_valid_i) |-> !mid_range_select_n_o[3]; endproperty
   a_csel: assert property (p_csel) else $error("coprocessor select missing");
   property p_psel; live |-> peripheral_select_n_o[0] == !$past(phit); endproperty
   a_psel: assert property (p_psel) else $error("peripheral select wrong");
   property p_addr; live && $past(addr_out_mode_i && cycle_valid_i) |-> periph_select5_or_addr1_o == $past(cycle_addr_i[1]);
   endproperty
   a_addr: assert property (p_addr) else $error("address bit pin wrong");
   property p_irq; s_err_op |=> err_irq_o && err_irq_type_o == 8'h10; endproperty
   a_irq: assert property (p_irq) else $error("error interrupt missing");
   property p_irq_why; err_irq_o |-> $past(numerics_op_start_i) && err_irq_type_o == 8'h10; endproperty
   a_irq_why: assert property (p_irq_why) else $error("interrupt without op start");
   property p_rst; disable iff (1'b0) !rst_n_i |=> mid_range_select_n_o == 4'hf && peripheral_select_n_o == 5'h1f;
   endproperty
   a_rst: assert property (p_rst) else $error("select low in reset");
endmodule // csp_chk
bind csp_chip_select csp_chk i_csp_chk (.*);

// ==== verification/csp_chip_select_tb_top.sv ====
// csp_chip_select_tb_top: directed bench for selects and coprocessor handshake
// assumes: checker bound by its own file
`timescale 1ns/1ps
module csp_chip_select_tb_top;
   import csp_pkg::*;
   logic clk_i = 1'b0, rst_n_i = 1'b0, cycle_valid_i = 1'b0, cycle_is_io_i = 1'b0, mid_enable_i = 1'b1;
   logic addr_out_mode_i = 1'b0, numerics_mode_i = 1'b0, coproc_access_i = 1'b0, numerics_op_start_i = 1'b0;
   logic req_cmd = 1'b0, err_cmd = 1'b0, coproc_transfer_request_i, coproc_error_i, coproc_request_seen_o;
   logic coproc_busy_o, err_irq_o, periph_select5_or_addr1_o, periph_select6_or_addr2_o;
   logic [ADDR_W-1:0]          cycle_addr_i = 20'h00000, mid_lo_i = 20'h08000, mid_hi_i = 20'h08fff;
   logic [PERIPH_N*ADDR_W-1:0] periph_lo_i, periph_hi_i;
   logic [MID_N-1:0]           mid_range_select_n_o;
   logic [PERIPH_LOW-1:0]      peripheral_select_n_o;
   logic [7:0]                 err_irq_type_o;
   int                         error_cnt = 0, n_compared = 0;
   csp_chip_select i_csp_chip_select (.*);
   csp_coproc_model i_csp_coproc_model (.clk_i(clk_i), .req_cmd_i(req_cmd), .err_cmd_i(err_cmd),
                                        .req_o(coproc_transfer_request_i), .err_o(coproc_error_i));
   initial forever #4 clk_i = ~clk_i;
   // ==========================================================
   // tasks
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task cyc(input logic io, input logic [ADDR_W-1:0] a);
      @(negedge clk_i);
      cycle_valid_i = 1'b1;
      cycle_is_io_i = io;
      cycle_addr_i  = a;
      @(negedge clk_i);
      cycle_valid_i = 1'b0;
   endtask
   task conclude;
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // ==========================================================
   // sequence of tests
   initial
   begin
      for (int k = 0; k < PERIPH_N; k++)
      begin
         periph_lo_i[k*ADDR_W +: ADDR_W] = ADDR_W'(k * 256);
         periph_hi_i[k*ADDR_W +: ADDR_W] = ADDR_W'(k * 256 + 255);
      end
      repeat (20) @(negedge clk_i);
      chk({mid_range_select_n_o, peripheral_select_n_o}, 9'h1ff);
      rst_n_i = 1'b1;
      cyc(1'b0, 20'h08000);
      chk(mid_range_select_n_o, 4'h0);
      cyc(1'b1, 20'h08fff);
      chk(mid_range_select_n_o, 4'hf);
      cyc(1'b0, 20'h09000);
      chk(mid_range_select_n_o, 4'hf);
      mid_enable_i = 1'b0;
      cyc(1'b0, 20'h08fff);
      chk(mid_range_select_n_o, 4'hf);
      $display("mid range test done");
      for (int k = 0; k < PERIPH_N; k++)
      begin
         cyc(k[0], ADDR_W'(k * 256 + 255));
         chk({periph_select6_or_addr2_o, periph_select5_or_addr1_o, peripheral_select_n_o}, 7'h7f & ~(7'h01 << k));
      end
      addr_out_mode_i = 1'b1;
      cyc(1'b0, 20'h09006);
      chk({periph_select6_or_addr2_o, periph_select5_or_addr1_o}, 2'b11);
      cyc(1'b1, 20'h09004);
      chk({periph_select6_or_addr2_o, periph_select5_or_addr1_o}, 2'b10);
      $display("peripheral test done");
      numerics_mode_i = 1'b1;
      mid_enable_i    = 1'b1;
      cyc(1'b0, 20'h08000);
      chk(mid_range_select_n_o, 4'hb);
      coproc_access_i = 1'b1;
      cyc(1'b0, 20'h09000);
      chk(mid_range_select_n_o, 4'h7);
      req_cmd = 1'b1;
      repeat (8) if (coproc_request_seen_o !== 1'b1) @(negedge clk_i);
      chk(coproc_request_seen_o, 1'b1);
      if (coproc_request_seen_o !== 1'b1) conclude;
      err_cmd = 1'b1;
      repeat (4) @(negedge clk_i);
      numerics_op_start_i = 1'b1;
      @(negedge clk_i);
      numerics_op_start_i = 1'b0;
      chk({err_irq_o, err_irq_type_o}, 9'h110);
      @(negedge clk_i);
      chk(err_irq_o, 1'b0);
      chk(coproc_busy_o, 1'b1);
      req_cmd = 1'b0;
      err_cmd = 1'b0;
      repeat (8) if (coproc_busy_o !== 1'b0) @(negedge clk_i);
      chk({coproc_busy_o, coproc_request_seen_o}, 2'b00);
      $display("coprocessor test done");
      conclude;
   end
endmodule // csp_chip_select_tb_top

// ==== verification/csp_coproc_model.sv ====
// csp_coproc_model: coprocessor request and error lines
// assumes: commands taken on the rising edge, lines move on the falling edge
`timescale 1ns/1ps
module csp_coproc_model
(
   input  wire logic clk_i,
   input  wire logic req_cmd_i,
   input  wire logic err_cmd_i,
   output logic      req_o = 1'b0,
   output logic      err_o = 1'b0
);
   logic req_q = 1'b0;
   logic err_q = 1'b0;
   always @(posedge clk_i) req_q <= req_cmd_i;
   always @(posedge clk_i) err_q <= err_cmd_i;
   always @(negedge clk_i) req_o <= req_q;
   always @(negedge clk_i) err_o <= err_q;
endmodule // csp_coproc_model
